// >>> core/lssl_host.sv
// Host end: buffers frames and shifts them out, then pulses the latch load.
`timescale 1ns/100ps
module lssl_host
    import lssl_pkg::*;
(
    input  wire logic              clock,
    input  wire logic              reset,
    input  wire lssl_pkg::lssl_word_t frame_data,
    input  wire logic              frame_valid,
    output logic                   frame_ready,
    input  wire logic              gate_n_in,
    output logic                   busy,
    lssl_if.host                   link
);
    import lssl_pkg::*;

    lssl_word_t  buf_q [BUF_DEPTH];
    logic        wr_ptr_q;
    logic        rd_ptr_q;
    logic [1:0]  count_q;
    lssl_state_e state_q;
    lssl_word_t  shift_q;
    logic [4:0]  bits_q;
    logic [2:0]  div_q;
    logic        sd_q;
    logic        sc_q;
    logic        ll_q;
    logic        gn_q;
    logic        busy_q;

    wire buf_push = frame_valid && (count_q != 2'(BUF_DEPTH));
    wire buf_pop  = (state_q == LSSL_IDLE) && (count_q != 2'd0);
    wire div_done = (div_q == 3'(CLK_HALF_CYCLES - 1));
    wire last_bit = (bits_q == 5'(FRAME_BITS - 1));

    always_ff @(posedge clock) begin
        if (buf_push) begin
            buf_q[wr_ptr_q] <= frame_data;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            wr_ptr_q <= 1'b0;
            rd_ptr_q <= 1'b0;
            count_q  <= 2'd0;
            frame_ready <= 1'b0;
        end else begin
            if (buf_push) begin
                wr_ptr_q <= ~wr_ptr_q;
            end
            if (buf_pop) begin
                rd_ptr_q <= ~rd_ptr_q;
            end
            count_q <= count_q + 2'(buf_push) - 2'(buf_pop);
            frame_ready <= (count_q + 2'(buf_push) - 2'(buf_pop)) != 2'(BUF_DEPTH);
        end
    end

    // Data changes only while the clock is low, so it is steady at each rising edge.
    always_ff @(posedge clock) begin
        if (reset) begin
            state_q <= LSSL_IDLE;
            shift_q <= SHIFT_RESET;
            bits_q  <= 5'd0;
            div_q   <= 3'd0;
            sd_q    <= 1'b0;
            sc_q    <= 1'b0;
            ll_q    <= 1'b0;
            busy_q  <= 1'b0;
        end else begin
            unique case (state_q)
                LSSL_IDLE: begin
                    div_q <= 3'd0;
                    if (buf_pop) begin
                        shift_q <= buf_q[rd_ptr_q];
                        sd_q    <= buf_q[rd_ptr_q][FRAME_BITS-1];
                        bits_q  <= 5'd0;
                        busy_q  <= 1'b1;
                        state_q <= LSSL_LOW;
                    end else begin
                        busy_q  <= 1'b0;
                    end
                end
                LSSL_LOW: begin
                    div_q <= div_done ? 3'd0 : div_q + 3'd1;
                    if (div_done) begin
                        sc_q    <= 1'b1;
                        state_q <= LSSL_HIGH;
                    end
                end
                LSSL_HIGH: begin
                    div_q <= div_done ? 3'd0 : div_q + 3'd1;
                    if (div_done) begin
                        sc_q <= 1'b0;
                        if (last_bit) begin
                            ll_q    <= 1'b1;
                            state_q <= LSSL_LOAD;
                        end else begin
                            shift_q <= {shift_q[FRAME_BITS-2:0], 1'b0};
                            sd_q    <= shift_q[FRAME_BITS-2];
                            bits_q  <= bits_q + 5'd1;
                            state_q <= LSSL_LOW;
                        end
                    end
                end
                LSSL_LOAD: begin
                    div_q <= div_done ? 3'd0 : div_q + 3'd1;
                    if (div_done) begin
                        ll_q    <= 1'b0;
                        state_q <= LSSL_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            gn_q <= 1'b1;
        end else begin
            gn_q <= gate_n_in;
        end
    end

    assign link.serial_data  = sd_q;
    assign link.serial_clock = sc_q;
    assign link.latch_load   = ll_q;
    assign link.gate_n       = gn_q;
    assign busy              = busy_q;
endmodule

// >>> core/lssl_pkg.sv
// Package with the shared constants of the LED sink shift-latch link.
package lssl_pkg;
    localparam int FRAME_BITS      = 16;
    localparam int SYNC_STAGES     = 3;
    localparam logic [15:0] SHIFT_RESET = 16'h0000;
    localparam logic [15:0] LATCH_RESET = 16'h0000;
    localparam int CLK_HALF_CYCLES = 4;
    localparam int BUF_DEPTH       = 2;
    typedef logic [FRAME_BITS-1:0] lssl_word_t;
    typedef enum logic [1:0] {
        LSSL_IDLE  = 2'b00,
        LSSL_LOW   = 2'b01,
        LSSL_HIGH  = 2'b11,
        LSSL_LOAD  = 2'b10
    } lssl_state_e;
endpackage

// >>> core/lssl_if.sv
// Interface joining the host end and the driver end of the serial link.
`timescale 1ns/100ps
interface lssl_if;
    logic       serial_data;
    logic       serial_clock;
    logic       latch_load;
    logic       gate_n;
    logic       cascade_out;
    modport host (
        output serial_data,
        output serial_clock,
        output latch_load,
        output gate_n,
        input  cascade_out
    );
    modport device (
        input  serial_data,
        input  serial_clock,
        input  latch_load,
        input  gate_n,
        output cascade_out
    );
endinterface

// >>> core/lssl_device.sv
// Driver end: shift register, cascade output, transparent latch and gated sinks.
`timescale 1ns/100ps
module lssl_device
    import lssl_pkg::*;
(
    input  wire logic                 clock,
    input  wire logic                 reset,
    lssl_if.device                    link,
    output lssl_pkg::lssl_word_t      sink_channels,
    output lssl_pkg::lssl_word_t      sink_channels_oe,
    output lssl_pkg::lssl_word_t      latch_view
);
    import lssl_pkg::*;

    logic [SYNC_STAGES-1:0] sc_sync_q;
    logic [SYNC_STAGES-1:0] sd_sync_q;
    logic [SYNC_STAGES-1:0] ll_sync_q;
    logic [SYNC_STAGES-1:0] gn_sync_q;
    logic                   sc_lvl_q;
    logic                   ll_lvl_q;
    logic                   gn_lvl_q;
    lssl_word_t             shift_q;
    lssl_word_t             latch_q;
    logic                   cascade_q;
    lssl_word_t             oe_q;

    // Only stages one and two are compared; stage zero is the pure synchroniser.
    wire sc_agree = sc_sync_q[1] == sc_sync_q[2];
    wire ll_agree = ll_sync_q[1] == ll_sync_q[2];
    wire gn_agree = gn_sync_q[1] == gn_sync_q[2];
    wire sc_rise  = sc_agree && sc_sync_q[2] && !sc_lvl_q;
    wire ll_level = ll_agree ? ll_sync_q[2] : ll_lvl_q;
    wire gn_level = gn_agree ? gn_sync_q[2] : gn_lvl_q;
    // Data is taken from the same stage depth as the clock, so setup is preserved.
    wire        data_bit   = sd_sync_q[2];
    wire [15:0] shift_next = sc_rise ? {shift_q[FRAME_BITS-2:0], data_bit} : shift_q;

    always_ff @(posedge clock) begin
        if (reset) begin
            sc_sync_q <= '0;
            sd_sync_q <= '0;
            ll_sync_q <= '0;
            gn_sync_q <= '1;
            sc_lvl_q  <= 1'b0;
            ll_lvl_q  <= 1'b0;
            gn_lvl_q  <= 1'b1;
        end else begin
            sc_sync_q <= {sc_sync_q[1:0], link.serial_clock};
            sd_sync_q <= {sd_sync_q[1:0], link.serial_data};
            ll_sync_q <= {ll_sync_q[1:0], link.latch_load};
            gn_sync_q <= {gn_sync_q[1:0], link.gate_n};
            if (sc_agree) begin
                sc_lvl_q <= sc_sync_q[2];
            end
            ll_lvl_q <= ll_level;
            gn_lvl_q <= gn_level;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            shift_q   <= SHIFT_RESET;
            latch_q   <= LATCH_RESET;
            cascade_q <= 1'b0;
            oe_q      <= '0;
        end else begin
            shift_q <= shift_next;
            if (sc_rise) begin
                cascade_q <= shift_q[FRAME_BITS-1];
            end
            if (ll_level) begin
                latch_q <= shift_next;
            end
            // Open-drain sink: enabled means pulling low, lighting the LED.
            oe_q <= gn_level ? '0 : latch_q;
        end
    end

    assign link.cascade_out  = cascade_q;
    assign sink_channels     = '0;
    assign sink_channels_oe  = oe_q;
    assign latch_view        = latch_q;
endmodule

// >>> test/lssl_link_assertions.sv
// Checker of the serial link between the host end and the driver end.
`timescale 1ns/100ps
module lssl_link_assertions (
    input wire logic clock,
    input wire logic reset,
    input wire logic serial_data,
    input wire logic serial_clock,
    input wire logic latch_load,
    input wire logic cascade_out
);
    logic [15:0] ref_q;
    logic        out_q;
    logic [4:0]  rises_q;
    logic [5:0]  hist_q;
    // The reference register shifts on the same edges the driver should see.
    always_ff @(posedge clock) begin
        if (reset) begin
            ref_q   <= 16'h0000;
            out_q   <= 1'b0;
            rises_q <= 5'h00;
        end else if ($rose(serial_clock)) begin
            ref_q   <= {ref_q[14:0], serial_data};
            out_q   <= ref_q[15];
            rises_q <= rises_q + 5'h01;
        end else if ($fell(latch_load)) begin
            rises_q <= 5'h00;
        end
    end
    always_ff @(posedge clock) begin
        hist_q <= reset ? 6'h00 : {hist_q[4:0], serial_clock};
    end
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    data_hold_a: assert property (
        serial_clock && $past(serial_clock) |-> $stable(serial_data)) else $error("data moved");
    data_setup_a: assert property (
        $rose(serial_clock) |-> $stable(serial_data)) else $error("data moved at rise");
    clock_high_a: assert property (
        $rose(serial_clock) |-> serial_clock[*4] ##1 !serial_clock) else $error("bad half period");
    frame_len_a: assert property (
        $rose(latch_load) |-> rises_q == 5'h10) else $error("frame not sixteen bits");
    latch_len_a: assert property (
        $rose(latch_load) |-> latch_load[*4] ##1 !latch_load) else $error("bad latch pulse");
    no_shift_a: assert property (
        latch_load |-> !$rose(serial_clock)) else $error("shift during latch load");
    cascade_bit_a: assert property (
        $rose(serial_clock) |-> cascade_out == out_q) else $error("wrong cascade bit");
    cascade_hold_a: assert property (
        $changed(cascade_out) |-> |hist_q) else $error("cascade moved without clock");
    cover property ($rose(latch_load));
    cover property ($changed(cascade_out));
    cover property ($fell(latch_load) ##[1:20] $rose(serial_clock));
endmodule

// >>> test/led_sink_shift_latch_tb.sv
// Self-checking bench joining the host end to the driver end.
`timescale 1ns/100ps
module led_sink_shift_latch_tb;
    import lssl_pkg::*;
    logic       clock;
    logic       reset;
    lssl_word_t frame_data;
    logic       frame_valid;
    logic       frame_ready;
    logic       gate_n_in;
    logic       busy;
    lssl_word_t oe;
    lssl_word_t latch_view;
    int         errors;
    int         samples_checked;
    lssl_if link ();
    lssl_host u_lssl_host (.clock(clock), .reset(reset), .frame_data(frame_data),
        .frame_valid(frame_valid), .frame_ready(frame_ready), .gate_n_in(gate_n_in),
        .busy(busy), .link(link.host));
    lssl_device u_lssl_device (.clock(clock), .reset(reset), .link(link.device),
        .sink_channels(), .sink_channels_oe(oe), .latch_view(latch_view));
    lssl_link_assertions u_lssl_link_assertions (.clock(clock), .reset(reset),
        .serial_data(link.serial_data), .serial_clock(link.serial_clock),
        .latch_load(link.latch_load), .cascade_out(link.cascade_out));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        if (errors == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic pause(input int k);
        repeat (k) @(negedge clock);
    endtask
    // The edge before raising valid keeps back-to-back pushes from colliding.
    task automatic send(input lssl_word_t word);
        int n;
        @(negedge clock);
        frame_data = word;
        frame_valid = 1'b1;
        for (n = 0; n < 100 && frame_ready !== 1'b1; n++) @(negedge clock);
        if (n == 100) begin
            errors++;
            report_and_stop();
        end
        @(negedge clock);
        frame_valid = 1'b0;
    endtask
    task automatic settle();
        int n;
        int quiet;
        quiet = 0;
        for (n = 0; n < 3000 && quiet < 12; n++) begin
            @(negedge clock);
            quiet = (busy !== 1'b0 || link.latch_load !== 1'b0) ? 0 : quiet + 1;
        end
        if (quiet < 12) begin
            errors++;
            report_and_stop();
        end
    endtask
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    initial begin
        reset = 1'b1;
        frame_data = 16'h0000;
        frame_valid = 1'b0;
        gate_n_in = 1'b1;
        errors = 0;
        samples_checked = 0;
        pause(6);
        reset = 1'b0;
        pause(1);
        check(latch_view, 16'h0000);
        check(oe, 16'h0000);
        send(16'hA5C3);
        settle();
        check(latch_view, 16'hA5C3);
        check(oe, 16'h0000);
        gate_n_in = 1'b0;
        pause(8);
        check(oe, 16'hA5C3);
        send(16'h8001);
        send(16'h7FFE);
        settle();
        check(latch_view, 16'h7FFE);
        check({15'h0000, link.cascade_out}, 16'h0001);
        send(16'h1234);
        pause(40);
        check(latch_view, 16'h7FFE);
        gate_n_in = 1'b1;
        pause(8);
        check(oe, 16'h0000);
        settle();
        check(latch_view, 16'h1234);
        check({15'h0000, link.cascade_out}, 16'h0000);
        gate_n_in = 1'b0;
        pause(8);
        check(oe, 16'h1234);
        reset = 1'b1;
        pause(2);
        reset = 1'b0;
        pause(1);
        check(latch_view, 16'h0000);
        check(oe, 16'h0000);
        report_and_stop();
    end
endmodule
